/* rtl/two_pkg.sv */
// ****************************************************************
// shared constants for the word-table engine and its sequencer
// ****************************************************************
package two_pkg;
   localparam int WORD_W = 16; // bits in one table word
   localparam int LEN_W = 8; // table length operand width, 0..ff
   localparam int OCT_DIGITS = 4; // octal digits in a shift count
   localparam int SHIFT_W = 3 * OCT_DIGITS; // binary shift count width
   localparam int CNT_W = 16; // pass counter width
   localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000; // cleared word
   localparam logic [LEN_W-1:0] LEN_ONE = 8'h01; // one word step
   localparam logic [WORD_W-1:0] CNT_STEP = 16'h0001; // counter step

   // operation selector from the sequencer
   typedef enum logic [2:0] {
      TWO_ADD_TO_TOP_OP = 3'h0,
      TWO_TABLE_SHIFT_LEFT_OP = 3'h1,
      TWO_TABLE_SHIFT_RIGHT_OP = 3'h2,
      TWO_AND_MOVE_OP = 3'h3,
      TWO_OR_MOVE_OP = 3'h4,
      TWO_XOR_MOVE_OP = 3'h5
   } two_op_t;

   // engine states, gray codes in declaration order
   typedef enum logic [2:0] {
      TWO_IDLE = 3'h0,
      TWO_ADD_MOVE = 3'h1,
      TWO_ADD_PUT = 3'h3,
      TWO_ADD_CNT = 3'h2,
      TWO_SHIFT = 3'h6,
      TWO_MOVE = 3'h7,
      TWO_FINISH = 3'h5
   } two_state_t;
endpackage

/* rtl/two_link_if.sv */
`timescale 1ns/1ps
// ****************************************************************
// link between instruction sequencer and table engine
// ****************************************************************
interface two_link_if #(parameter int ADDR_W = 10) (
   input wire logic core_clk,
   input wire logic rst_n
);
   import two_pkg::*;
   logic req_valid; // one-cycle request pulse
   two_op_t req_op; // selected operation
   logic [LEN_W-1:0] req_len; // first stack level: table length
   logic [ADDR_W-1:0] req_addr; // accumulator: table start
   logic [WORD_W-1:0] req_operand; // source word, shift count or pattern
   logic [ADDR_W-1:0] req_dest; // move destination start
   logic scan_end; // one-cycle end-of-scan pulse
   logic mem_wr; // word write pulse
   logic mem_rd; // word read pulse
   logic [ADDR_W-1:0] mem_addr; // word address
   logic [WORD_W-1:0] mem_wdata; // word write data
   logic [WORD_W-1:0] mem_rdata; // word read data
   logic mem_rvalid; // read data pulse
   logic busy; // operation in progress
   logic done; // operation complete pulse
   logic table_counter_flag; // counter reached length
   logic over_shift_flag; // shift count beyond table bits
   logic shift_carry_out_flag; // last discarded bit was one

   modport engine (
      input req_valid, req_op, req_len, req_addr, req_operand, req_dest, scan_end,
      input mem_wr, mem_rd, mem_addr, mem_wdata,
      output mem_rdata, mem_rvalid, busy, done,
      output table_counter_flag, over_shift_flag, shift_carry_out_flag
   );
   modport sequencer (
      output req_valid, req_op, req_len, req_addr, req_operand, req_dest, scan_end,
      output mem_wr, mem_rd, mem_addr, mem_wdata,
      input mem_rdata, mem_rvalid, busy, done,
      input table_counter_flag, over_shift_flag, shift_carry_out_flag
   );
endinterface

/* rtl/two_rising_edge_one_shot.sv */
`timescale 1ns/1ps
// ****************************************************************
// once-per-scan rising edge detector for the rung input
// ****************************************************************
module two_rising_edge_one_shot (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic sample_en,
   input wire logic level_in,
   output logic pulse_out
);
   logic prev_r; // level seen at the previous scan

   // remember the level once per scan
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 1'b0;
      end else if (sample_en) begin
         prev_r <= level_in;
      end
   end

   // true for the one scan in which the level went high
   assign pulse_out = sample_en & level_in & ~prev_r;
endmodule

/* rtl/two_engine.sv */
`timescale 1ns/1ps
module two_engine import two_pkg::*; #(
   parameter int ADDR_W = 10
) (
   input wire logic core_clk,
   input wire logic rst_n,
   two_link_if.engine link
);
   // ****************************************************************
   // parameter check
   // ****************************************************************
   if (ADDR_W < LEN_W + 1 || ADDR_W > 16) begin : g_bad_addr
      $error("two_engine: ADDR_W must lie between 9 and 16");
   end

   localparam int DEPTH = 1 << ADDR_W; // words of table memory

   // ****************************************************************
   // storage and state
   // ****************************************************************
   logic [WORD_W-1:0] mem [DEPTH]; // controller word memory
   two_state_t state_r; // sequence state
   two_op_t op_r; // operation being run
   logic [LEN_W-1:0] len_r; // table length in words
   logic [ADDR_W-1:0] addr_r; // table start
   logic [ADDR_W-1:0] dest_r; // move destination start
   logic [WORD_W-1:0] acc_r; // source word or pattern
   logic [LEN_W-1:0] idx_r; // word index in the table
   logic [WORD_W-1:0] cnt_r; // table counter seen at start
   logic carry_r; // bit travelling between words
   logic last_out_r; // last bit dropped off the table end
   logic [CNT_W-1:0] pass_r; // shift passes done
   logic [CNT_W-1:0] pass_lim_r; // shift passes to run
   logic over_r; // over-shift result
   logic full_r; // table full result
   logic busy_r; // busy output
   logic done_r; // done output
   logic rvalid_r; // read valid output
   logic [WORD_W-1:0] rdata_r; // read data output
   logic cnt_flag_r; // table counter flag
   logic over_flag_r; // over-shift flag
   logic carry_flag_r; // carry-out flag

   // ****************************************************************
   // combinational helpers
   // ****************************************************************
   logic [WORD_W-1:0] start_cnt; // counter word at request start
   logic [ADDR_W-1:0] rd_addr; // current table word address
   logic [WORD_W-1:0] rd_word; // current table word
   logic [11:0] total_bits; // bits held by the table
   logic [SHIFT_W-1:0] shift_n; // requested shift count
   logic shl; // shift toward higher positions
   logic pass_last_word; // last word of a shift pass
   logic [WORD_W-1:0] shifted; // word after one-bit shift
   logic shift_out; // bit leaving the current word
   logic [WORD_W-1:0] moved; // word after logic combine
   logic we; // memory write enable
   logic [ADDR_W-1:0] wa; // memory write address
   logic [WORD_W-1:0] wd; // memory write data
   logic accept; // request taken this cycle
   logic add_ok; // counter allows an addition

   assign start_cnt = mem[link.req_addr];
   assign rd_addr = ADDR_W'(addr_r + ADDR_W'(idx_r));
   assign rd_word = mem[rd_addr];
   // taken from the request itself, not from the previous operation
   assign total_bits = {4'h0, link.req_len} << 4;
   assign shift_n = link.req_operand[SHIFT_W-1:0];
   assign shl = (op_r == TWO_TABLE_SHIFT_LEFT_OP);
   assign accept = (state_r == TWO_IDLE) && link.req_valid;
   // zero, equal to or above length stops it
   assign add_ok = (start_cnt != WORD_ZERO) && (start_cnt < {8'h00, link.req_len});
   assign pass_last_word = shl ? (idx_r == len_r - LEN_ONE) : (idx_r == '0);

   // one-bit shift of the current word with the incoming carry
   always_comb begin
      if (shl) begin
         shifted = {rd_word[WORD_W-2:0], carry_r};
         shift_out = rd_word[WORD_W-1];
      end else begin
         shifted = {carry_r, rd_word[WORD_W-1:1]};
         shift_out = rd_word[0];
      end
   end

   // logic combine for the move operations
   always_comb begin
      case (op_r)
         TWO_AND_MOVE_OP: moved = rd_word & acc_r;
         TWO_OR_MOVE_OP: moved = rd_word | acc_r;
         TWO_XOR_MOVE_OP: moved = rd_word ^ acc_r;
         default: moved = rd_word;
      endcase
   end

   // single memory write port
   always_comb begin
      we = 1'b0;
      wa = link.mem_addr;
      wd = link.mem_wdata;
      case (state_r)
         TWO_IDLE: begin
            we = link.mem_wr && !link.req_valid;
         end
         TWO_ADD_MOVE: begin
            we = 1'b1;
            wa = ADDR_W'(rd_addr + ADDR_W'(1));
            wd = rd_word;
         end
         TWO_ADD_PUT: begin
            we = 1'b1;
            wa = ADDR_W'(addr_r + ADDR_W'(1));
            wd = acc_r;
         end
         TWO_ADD_CNT: begin
            we = 1'b1;
            wa = addr_r;
            wd = cnt_r + CNT_STEP;
         end
         TWO_SHIFT: begin
            we = 1'b1;
            wa = rd_addr;
            wd = shifted;
         end
         TWO_MOVE: begin
            we = 1'b1;
            wa = ADDR_W'(dest_r + ADDR_W'(idx_r));
            wd = moved;
         end
         default: begin
            we = 1'b0;
         end
      endcase
   end

   // ****************************************************************
   // memory
   // ****************************************************************
   // word array, no reset
   always_ff @(posedge core_clk) begin
      if (we) begin
         mem[wa] <= wd;
      end
   end

   // word reads for the sequencer, only while idle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_r <= 1'b0;
         rdata_r <= WORD_ZERO;
      end else begin
         rvalid_r <= (state_r == TWO_IDLE) && link.mem_rd && !link.req_valid;
         if ((state_r == TWO_IDLE) && link.mem_rd) begin
            rdata_r <= mem[link.mem_addr];
         end
      end
   end

   // ****************************************************************
   // sequence control
   // ****************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= TWO_IDLE;
         op_r <= TWO_ADD_TO_TOP_OP;
         len_r <= '0;
         addr_r <= '0;
         dest_r <= '0;
         acc_r <= WORD_ZERO;
         idx_r <= '0;
         cnt_r <= WORD_ZERO;
         carry_r <= 1'b0;
         last_out_r <= 1'b0;
         pass_r <= '0;
         pass_lim_r <= '0;
         over_r <= 1'b0;
         full_r <= 1'b0;
      end else begin
         case (state_r)
            TWO_IDLE: begin
               if (accept) begin
                  op_r <= link.req_op;
                  len_r <= link.req_len;
                  addr_r <= link.req_addr;
                  dest_r <= link.req_dest;
                  acc_r <= link.req_operand;
                  cnt_r <= start_cnt;
                  carry_r <= 1'b0;
                  last_out_r <= 1'b0;
                  pass_r <= '0;
                  over_r <= ({4'h0, shift_n} > {4'h0, total_bits});
                  // beyond the table every extra pass only drops zeros
                  pass_lim_r <= ({4'h0, shift_n} > {4'h0, total_bits}) ?
                                CNT_W'({4'h0, total_bits} + 16'h0001) : CNT_W'(shift_n);
                  full_r <= (start_cnt == {8'h00, link.req_len});
                  case (link.req_op)
                     TWO_ADD_TO_TOP_OP: begin
                        state_r <= add_ok ? TWO_ADD_MOVE : TWO_FINISH;
                        idx_r <= start_cnt[LEN_W-1:0];
                     end
                     TWO_TABLE_SHIFT_LEFT_OP, TWO_TABLE_SHIFT_RIGHT_OP: begin
                        state_r <= (link.req_len == '0 || shift_n == '0) ? TWO_FINISH : TWO_SHIFT;
                        idx_r <= (link.req_op == TWO_TABLE_SHIFT_LEFT_OP) ? '0 : link.req_len - LEN_ONE;
                     end
                     TWO_AND_MOVE_OP, TWO_OR_MOVE_OP, TWO_XOR_MOVE_OP: begin
                        state_r <= (link.req_len == '0) ? TWO_FINISH : TWO_MOVE;
                        idx_r <= '0;
                     end
                     default: begin
                        state_r <= TWO_FINISH;
                     end
                  endcase
               end
            end
            TWO_ADD_MOVE: begin
               // walk from the bottom entry up, one word per cycle
               if (idx_r == LEN_ONE) begin
                  state_r <= TWO_ADD_PUT;
               end else begin
                  idx_r <= idx_r - LEN_ONE;
               end
            end
            TWO_ADD_PUT: begin
               state_r <= TWO_ADD_CNT;
            end
            TWO_ADD_CNT: begin
               full_r <= ((cnt_r + CNT_STEP) == {8'h00, len_r});
               state_r <= TWO_FINISH;
            end
            TWO_SHIFT: begin
               if (pass_last_word) begin
                  last_out_r <= shift_out;
                  carry_r <= 1'b0;
                  pass_r <= pass_r + CNT_W'(1);
                  idx_r <= shl ? '0 : len_r - LEN_ONE;
                  if (pass_r + CNT_W'(1) == pass_lim_r) begin
                     state_r <= TWO_FINISH;
                  end
               end else begin
                  carry_r <= shift_out;
                  idx_r <= shl ? idx_r + LEN_ONE : idx_r - LEN_ONE;
               end
            end
            TWO_MOVE: begin
               if (idx_r == len_r - LEN_ONE) begin
                  state_r <= TWO_FINISH;
               end else begin
                  idx_r <= idx_r + LEN_ONE;
               end
            end
            TWO_FINISH: begin
               state_r <= TWO_IDLE;
            end
            default: begin
               state_r <= TWO_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // status outputs
   // ****************************************************************
   // busy from acceptance to finish, done for one cycle after
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         busy_r <= accept || (state_r != TWO_IDLE && state_r != TWO_FINISH);
         done_r <= (state_r == TWO_FINISH);
      end
   end

   // flags: cleared at scan end, rewritten by the next user; set wins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_flag_r <= 1'b0;
         over_flag_r <= 1'b0;
         carry_flag_r <= 1'b0;
      end else begin
         if (state_r == TWO_FINISH && op_r == TWO_ADD_TO_TOP_OP) begin
            cnt_flag_r <= full_r;
         end else if (link.scan_end) begin
            cnt_flag_r <= 1'b0;
         end
         if (state_r == TWO_FINISH && (op_r == TWO_TABLE_SHIFT_LEFT_OP || op_r == TWO_TABLE_SHIFT_RIGHT_OP)) begin
            over_flag_r <= over_r;
            carry_flag_r <= last_out_r;
         end else if (link.scan_end) begin
            over_flag_r <= 1'b0;
            carry_flag_r <= 1'b0;
         end
      end
   end

   assign link.busy = busy_r;
   assign link.done = done_r;
   assign link.mem_rdata = rdata_r;
   assign link.mem_rvalid = rvalid_r;
   assign link.table_counter_flag = cnt_flag_r;
   assign link.over_shift_flag = over_flag_r;
   assign link.shift_carry_out_flag = carry_flag_r;
endmodule

/* rtl/two_sequencer.sv */
`timescale 1ns/1ps
// ****************************************************************
// instruction sequencer end: issues one operation per scan
// ****************************************************************
module two_sequencer import two_pkg::*; #(
   parameter int ADDR_W = 10
) (
   input wire logic core_clk,
   input wire logic rst_n,
   two_link_if.sequencer link,
   input wire logic scan_tick,
   input wire logic rung_in,
   input wire logic one_shot_en,
   input wire two_op_t op_in,
   input wire logic [LEN_W-1:0] len_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [WORD_W-1:0] operand_in,
   input wire logic [ADDR_W-1:0] dest_in,
   input wire logic mem_wr_in,
   input wire logic mem_rd_in,
   input wire logic [ADDR_W-1:0] mem_addr_in,
   input wire logic [WORD_W-1:0] mem_wdata_in,
   output logic busy,
   output logic done,
   output logic table_counter_flag,
   output logic over_shift_flag,
   output logic shift_carry_out_flag,
   output logic [WORD_W-1:0] mem_rdata,
   output logic mem_rvalid
);
   logic edge_pulse; // rising edge of the rung this scan
   logic fire; // operation to run this scan
   logic pend_r; // request outstanding
   logic req_valid_r; // request pulse
   two_op_t req_op_r; // operation held for the engine
   logic [LEN_W-1:0] req_len_r; // table length
   logic [ADDR_W-1:0] req_addr_r; // table start
   logic [WORD_W-1:0] req_operand_r; // operand after decoding
   logic [ADDR_W-1:0] req_dest_r; // destination start
   logic scan_end_r; // scan boundary pulse
   logic mem_wr_r; // forwarded write
   logic mem_rd_r; // forwarded read
   logic [ADDR_W-1:0] mem_addr_r; // forwarded address
   logic [WORD_W-1:0] mem_wdata_r; // forwarded data
   logic [WORD_W-1:0] operand_dec; // operand as the engine wants it

   // ****************************************************************
   // enable and operand decoding
   // ****************************************************************
   two_rising_edge_one_shot u_one_shot (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .sample_en(scan_tick),
      .level_in(rung_in),
      .pulse_out(edge_pulse)
   );

   // level enable runs every scan, one-shot only on the edge
   assign fire = one_shot_en ? edge_pulse : (scan_tick & rung_in);

   // shift counts arrive as octal digits, one per nibble
   always_comb begin
      operand_dec = operand_in;
      if (op_in == TWO_TABLE_SHIFT_LEFT_OP || op_in == TWO_TABLE_SHIFT_RIGHT_OP) begin
         operand_dec = {4'h0, operand_in[14:12], operand_in[10:8],
                        operand_in[6:4], operand_in[2:0]};
      end
   end

   // ****************************************************************
   // request issue
   // ****************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_r <= 1'b0;
         req_valid_r <= 1'b0;
         req_op_r <= TWO_ADD_TO_TOP_OP;
         req_len_r <= '0;
         req_addr_r <= '0;
         req_operand_r <= WORD_ZERO;
         req_dest_r <= '0;
         scan_end_r <= 1'b0;
      end else begin
         scan_end_r <= scan_tick;
         req_valid_r <= 1'b0;
         if (fire && !pend_r) begin
            pend_r <= 1'b1;
            req_valid_r <= 1'b1;
            req_op_r <= op_in;
            req_len_r <= len_in;
            req_addr_r <= addr_in;
            req_operand_r <= operand_dec;
            req_dest_r <= dest_in;
         end else if (link.done) begin
            pend_r <= 1'b0;
         end
      end
   end

   // word access forwarding, held off while an operation runs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_wr_r <= 1'b0;
         mem_rd_r <= 1'b0;
         mem_addr_r <= '0;
         mem_wdata_r <= WORD_ZERO;
      end else begin
         mem_wr_r <= mem_wr_in && !pend_r && !fire;
         mem_rd_r <= mem_rd_in && !pend_r && !fire;
         mem_addr_r <= mem_addr_in;
         mem_wdata_r <= mem_wdata_in;
      end
   end

   // user-side status copies
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         done <= 1'b0;
         table_counter_flag <= 1'b0;
         over_shift_flag <= 1'b0;
         shift_carry_out_flag <= 1'b0;
         mem_rdata <= WORD_ZERO;
         mem_rvalid <= 1'b0;
      end else begin
         busy <= pend_r;
         done <= link.done;
         table_counter_flag <= link.table_counter_flag;
         over_shift_flag <= link.over_shift_flag;
         shift_carry_out_flag <= link.shift_carry_out_flag;
         mem_rdata <= link.mem_rdata;
         mem_rvalid <= link.mem_rvalid;
      end
   end

   assign link.req_valid = req_valid_r;
   assign link.req_op = req_op_r;
   assign link.req_len = req_len_r;
   assign link.req_addr = req_addr_r;
   assign link.req_operand = req_operand_r;
   assign link.req_dest = req_dest_r;
   assign link.scan_end = scan_end_r;
   assign link.mem_wr = mem_wr_r;
   assign link.mem_rd = mem_rd_r;
   assign link.mem_addr = mem_addr_r;
   assign link.mem_wdata = mem_wdata_r;
endmodule

/* tb/two_link_assertions.sv */
`timescale 1ns/1ps
// ****************************************************************
// link checker: engine answers, flag lifetime
// ****************************************************************
module two_link_assertions (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic req_valid,
   input wire logic busy,
   input wire logic done,
   input wire logic scan_end,
   input wire logic mem_rd,
   input wire logic mem_rvalid,
   input wire logic table_counter_flag,
   input wire logic over_shift_flag,
   input wire logic shift_carry_out_flag
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_done_one_cycle: assert property (done |=> !done)
      else $error("done longer than one cycle");
   chk_busy_ends_done: assert property ($fell(busy) |-> done)
      else $error("busy dropped without done");
   chk_busy_bounded: assert property ($rose(busy) |-> ##[1:1000] done)
      else $error("operation never finished");
   chk_take_sets_busy: assert property (req_valid && !busy && !done |=> busy)
      else $error("idle request not taken");
   chk_read_answers: assert property (mem_rd && !busy && !req_valid && !done |=> mem_rvalid)
      else $error("idle read not answered");
   chk_scan_clears: assert property (scan_end ##1 !done |-> !table_counter_flag && !over_shift_flag)
      else $error("flags not cleared at scan end");
   chk_flag_holds: assert property (!done && !$past(scan_end) |-> $stable(table_counter_flag))
      else $error("counter flag moved without cause");
   chk_over_no_carry: assert property (over_shift_flag |-> !shift_carry_out_flag)
      else $error("carry set with over-shift");
endmodule

/* tb/table_word_operations_bench.sv */
`timescale 1ns/1ps
// ****************************************************************
// bench: sequencer user side drives both ends
// ****************************************************************
module table_word_operations_bench;
   import two_pkg::*;
   logic core_clk = 1'b0; // 8 ns clock
   logic rst_n = 1'b0; // held low 12 cycles
   logic scan_tick = 1'b0, rung_in = 1'b0, one_shot_en = 1'b0, mem_wr_in = 1'b0, mem_rd_in = 1'b0;
   two_op_t op_in = TWO_ADD_TO_TOP_OP;
   logic [LEN_W-1:0] len_in = 8'h00;
   logic [9:0] addr_in = 10'h000, dest_in = 10'h000, mem_addr_in = 10'h000;
   logic [WORD_W-1:0] operand_in = 16'h0000, mem_wdata_in = 16'h0000, mem_rdata;
   logic busy, done, tcf, osf, scf, mem_rvalid;
   int mismatches = 0, cmp_count = 0, i, k;
   two_op_t mv[3] = '{TWO_AND_MOVE_OP, TWO_OR_MOVE_OP, TWO_XOR_MOVE_OP};
   logic [15:0] e0[3] = '{16'h2222, 16'h7777, 16'h5555};
   logic [15:0] e1[3] = '{16'h0000, 16'hffff, 16'hffff};
   always #4 core_clk = ~core_clk;
   two_link_if link (.core_clk(core_clk), .rst_n(rst_n));
   two_engine i_two_engine (.core_clk(core_clk), .rst_n(rst_n), .link(link));
   two_sequencer i_two_sequencer (.core_clk(core_clk), .rst_n(rst_n), .link(link), .scan_tick(scan_tick),
      .rung_in(rung_in), .one_shot_en(one_shot_en), .op_in(op_in), .len_in(len_in), .addr_in(addr_in),
      .operand_in(operand_in), .dest_in(dest_in), .mem_wr_in(mem_wr_in), .mem_rd_in(mem_rd_in),
      .mem_addr_in(mem_addr_in), .mem_wdata_in(mem_wdata_in), .busy(busy), .done(done),
      .table_counter_flag(tcf), .over_shift_flag(osf), .shift_carry_out_flag(scf),
      .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));
   two_link_assertions i_chk (.core_clk(core_clk), .rst_n(rst_n), .req_valid(link.req_valid),
      .busy(link.busy), .done(link.done), .scan_end(link.scan_end), .mem_rd(link.mem_rd),
      .mem_rvalid(link.mem_rvalid), .table_counter_flag(link.table_counter_flag),
      .over_shift_flag(link.over_shift_flag), .shift_carry_out_flag(link.shift_carry_out_flag));
   // step to just after the next rising edge
   task cyc;
      @(posedge core_clk);
      #1;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task fl(input logic t, input logic o, input logic c);
      chk({13'h0000, tcf, osf, scf}, {13'h0000, t, o, c});
   endtask
   task wr(input logic [9:0] a, input logic [15:0] d);
      cyc;
      mem_addr_in = a;
      mem_wdata_in = d;
      mem_wr_in = 1'b1;
      cyc;
      mem_wr_in = 1'b0;
   endtask
   // read one word, wait bounded for its answer
   task rd(input logic [9:0] a, input logic [15:0] e);
      int n;
      cyc;
      mem_addr_in = a;
      mem_rd_in = 1'b1;
      cyc;
      mem_rd_in = 1'b0;
      for (n = 0; n < 20 && mem_rvalid !== 1'b1; n++) cyc;
      chk({15'h0000, mem_rvalid}, 16'h0001);
      chk(mem_rdata, e);
   endtask
   // one scan with the rung on, then wait for done
   task run(input two_op_t o, input logic [7:0] l, input logic [9:0] a, input logic [15:0] p,
      input logic [9:0] d);
      int n;
      cyc;
      op_in = o;
      len_in = l;
      addr_in = a;
      operand_in = p;
      dest_in = d;
      rung_in = 1'b1;
      scan_tick = 1'b1;
      cyc;
      scan_tick = 1'b0;
      cyc;
      chk({15'h0000, busy}, 16'h0001);
      for (n = 0; n < 1200 && done !== 1'b1; n++) cyc;
      chk({15'h0000, done}, 16'h0001);
      rung_in = 1'b0;
      repeat (3) cyc;
   endtask
   // one scan with the rung at a given level, no answer expected
   task scan(input logic r);
      rung_in = r;
      scan_tick = 1'b1;
      cyc;
      scan_tick = 1'b0;
      repeat (20) cyc;
   endtask
   task results;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      #400000;
      mismatches++;
      results;
   end
   initial begin
      repeat (12) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      wr(10'h010, 16'h0002);
      wr(10'h011, 16'haaa1);
      wr(10'h012, 16'haaa2);
      run(TWO_ADD_TO_TOP_OP, 8'h06, 10'h010, 16'h1234, 10'h000);
      rd(10'h010, 16'h0003);
      rd(10'h011, 16'h1234);
      rd(10'h013, 16'haaa2);
      fl(1'b0, 1'b0, 1'b0);
      for (i = 5; i < 8; i++) run(TWO_ADD_TO_TOP_OP, 8'h06, 10'h010, 16'(i), 10'h000);
      rd(10'h010, 16'h0006);
      fl(1'b1, 1'b0, 1'b0);
      run(TWO_ADD_TO_TOP_OP, 8'h06, 10'h010, 16'heeee, 10'h000);
      rd(10'h010, 16'h0006);
      rd(10'h011, 16'h0007);
      wr(10'h010, 16'h0000);
      run(TWO_ADD_TO_TOP_OP, 8'h06, 10'h010, 16'heeee, 10'h000);
      rd(10'h011, 16'h0007);
      rd(10'h010, 16'h0000);
      wr(10'h040, 16'h0001);
      one_shot_en = 1'b1;
      scan(1'b0);
      run(TWO_ADD_TO_TOP_OP, 8'h04, 10'h040, 16'h0011, 10'h000);
      scan(1'b1);
      scan(1'b0);
      run(TWO_ADD_TO_TOP_OP, 8'h04, 10'h040, 16'h0022, 10'h000);
      rd(10'h040, 16'h0003);
      rd(10'h041, 16'h0022);
      rd(10'h042, 16'h0011);
      one_shot_en = 1'b0;
      $display("test add to top done");
      wr(10'h020, 16'h8001);
      wr(10'h021, 16'h8000);
      run(TWO_TABLE_SHIFT_LEFT_OP, 8'h02, 10'h020, 16'h0001, 10'h000);
      rd(10'h020, 16'h0002);
      rd(10'h021, 16'h0001);
      fl(1'b0, 1'b0, 1'b1);
      run(TWO_TABLE_SHIFT_RIGHT_OP, 8'h02, 10'h020, 16'h0004, 10'h000);
      rd(10'h020, 16'h1000);
      rd(10'h021, 16'h0000);
      fl(1'b0, 1'b0, 1'b0);
      wr(10'h020, 16'hffff);
      run(TWO_TABLE_SHIFT_LEFT_OP, 8'h02, 10'h020, 16'h0041, 10'h000);
      rd(10'h020, 16'h0000);
      fl(1'b0, 1'b1, 1'b0);
      $display("test table shift done");
      wr(10'h020, 16'h3333);
      wr(10'h021, 16'h9999);
      wr(10'h032, 16'habcd);
      for (k = 0; k < 3; k++) begin
         run(mv[k], 8'h02, 10'h020, 16'h6666, 10'h030);
         rd(10'h030, e0[k]);
         rd(10'h031, e1[k]);
         rd(10'h032, 16'habcd);
      end
      $display("test logical move done");
      results;
   end
endmodule
